// [logic/ipv_ctrl.sv]
// Interrupt priority and vector logic: level fields, vector base,
// fast interrupt selection and arbitration toward the processor core.
// Assumes request inputs are levels from logic on clk, and an Avalon-MM
// master that holds each request until waitrequest is low.
`default_nettype none

module ipv_ctrl #(
  parameter logic [15:0] VBA_RESET = ipv_pkg::IPV_RST_VBA_A // Variant reset
) (
  input  wire logic                           clk,             // System clock
  input  wire logic                           sys_rst,         // Sync reset
  input  wire logic [6:0]                     avs_address,     // Byte address
  input  wire logic                           avs_read,        // Read strobe
  input  wire logic                           avs_write,       // Write strobe
  input  wire logic [31:0]                    avs_writedata,   // Write data
  output logic [31:0]                         avs_readdata,    // Read data
  output logic                                avs_waitrequest, // Stall
  input  wire logic [ipv_pkg::IPV_NUM_SRC-1:0] irq_req,        // Requests
  output logic                                core_irq,        // Request to core
  output logic [1:0]                          core_level,      // Level 0..2
  output logic                                core_fast,       // Fast vector used
  output logic [ipv_pkg::IPV_VAB_W-1:0]       vector_address_bus // Vector
);
  import ipv_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [1:0]             lvl4_r, lvl4_nxt;     // General call field only
  logic [15:0]            lvl5_r, lvl5_nxt;     // irq_level_select_five
  logic [IPV_LVL6_W-1:0]  lvl6_r, lvl6_nxt;     // irq_level_select_six
  logic [IPV_BASE_W-1:0]  vbase_r, vbase_nxt;   // vector_base
  logic [IPV_VNUM_W-1:0]  fsel0_r, fsel0_nxt;   // fast_irq0_select
  logic [IPV_VNUM_W-1:0]  fsel1_r, fsel1_nxt;   // Fast interrupt 1 select
  logic [15:0]            flow0_r, flow0_nxt;   // fast0_address_low
  logic [IPV_FHIGH_W-1:0] fhigh0_r, fhigh0_nxt; // fast0_address_high
  logic [15:0]            flow1_r, flow1_nxt;   // Fast 1 address low
  logic [IPV_FHIGH_W-1:0] fhigh1_r, fhigh1_nxt; // Fast 1 address high
  logic                   ack_r, ack_nxt;       // Second cycle of an access
  logic [31:0]            rdata_r, rdata_nxt;   // Registered read data
  logic                   irq_r, irq_nxt;       // Core request
  logic [1:0]             clvl_r, clvl_nxt;     // Core level
  logic                   fast_r, fast_nxt;     // Fast vector flag
  logic [IPV_VAB_W-1:0]   vab_r, vab_nxt;       // Vector address

  logic [2*IPV_NUM_SRC-1:0] fields;             // All level fields, packed
  logic [IPV_NUM_SRC-1:0]   src_en;             // Field not disabled
  logic [1:0]               src_lvl [IPV_NUM_SRC]; // Decoded levels
  logic [IPV_NUM_SRC-1:0]   pend;               // Enabled and requesting
  logic [4:0]               idx;                // Register index
  logic                     wr_go;              // Write takes effect now
  logic                     rd_go;              // Capture read data now

  // ************************************************************
  // Level field layout and decode
  // ************************************************************
  // Packing order puts request i at bits 2i+1..2i, so sources run
  // general call, timer B 0..3, comparator A/B, interval timers 0/1
  // from the fifth register, then interval timer 2 upward to PWM fault
  assign fields = {lvl6_r, lvl5_r, lvl4_r};

  // One decoder per request; shared code keeps all fields alike
  for (genvar g = 0; g < IPV_NUM_SRC; g++) begin : g_dec
    ipv_lvl_dec u_dec (
      .field   (fields[2*g +: 2]),
      .enabled (src_en[g]),
      .level   (src_lvl[g])
    );
  end

  // A disabled request never counts as pending
  assign pend = irq_req & src_en;

  // ************************************************************
  // Avalon-MM handshake
  // ************************************************************
  // Every access waits one cycle so read data can come from a flop
  assign idx             = avs_address[6:2];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_go           = avs_write & ack_r;
  assign rd_go           = avs_read & ~ack_r;
  assign avs_readdata    = rdata_r;

  // Handshake and read data next state
  always_comb begin
    ack_nxt   = (avs_read | avs_write) & ~ack_r;
    rdata_nxt = rdata_r;
    if (rd_go) begin
      rdata_nxt = 32'h0; // Unmapped words and reserved bits read zero, except status bit 15
      unique case (idx)
        IPV_IDX_LVL4:   rdata_nxt[1:0]             = lvl4_r;
        IPV_IDX_LVL5:   rdata_nxt[15:0]            = lvl5_r;
        IPV_IDX_LVL6:   rdata_nxt[IPV_LVL6_W-1:0]  = lvl6_r;
        IPV_IDX_VBASE:  rdata_nxt[IPV_BASE_W-1:0]  = vbase_r;
        IPV_IDX_FSEL0:  rdata_nxt[IPV_VNUM_W-1:0]  = fsel0_r;
        IPV_IDX_FLOW0:  rdata_nxt[15:0]            = flow0_r;
        IPV_IDX_FHIGH0: rdata_nxt[IPV_FHIGH_W-1:0] = fhigh0_r;
        IPV_IDX_FSEL1:  rdata_nxt[IPV_VNUM_W-1:0]  = fsel1_r;
        IPV_IDX_FLOW1:  rdata_nxt[15:0]            = flow1_r;
        IPV_IDX_FHIGH1: rdata_nxt[IPV_FHIGH_W-1:0] = fhigh1_r;
        IPV_IDX_PEND: begin
          // Zero marks a pending request; spare bits read one
          rdata_nxt[15:0] = 16'hffff;
          rdata_nxt[IPV_NUM_SRC-1:0] = ~pend;
        end
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  // Handshake registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  // Reserved bits are not stored, so stray ones written there are
  // dropped and always read back as zero
  always_comb begin
    lvl4_nxt   = lvl4_r;
    lvl5_nxt   = lvl5_r;
    lvl6_nxt   = lvl6_r;
    vbase_nxt  = vbase_r;
    fsel0_nxt  = fsel0_r;
    fsel1_nxt  = fsel1_r;
    flow0_nxt  = flow0_r;
    fhigh0_nxt = fhigh0_r;
    flow1_nxt  = flow1_r;
    fhigh1_nxt = fhigh1_r;
    if (wr_go) begin
      unique case (idx)
        IPV_IDX_LVL4:   lvl4_nxt   = avs_writedata[1:0];
        IPV_IDX_LVL5:   lvl5_nxt   = avs_writedata[15:0];
        IPV_IDX_LVL6:   lvl6_nxt   = avs_writedata[IPV_LVL6_W-1:0];
        IPV_IDX_VBASE:  vbase_nxt  = avs_writedata[IPV_BASE_W-1:0];
        IPV_IDX_FSEL0:  fsel0_nxt  = avs_writedata[IPV_VNUM_W-1:0];
        IPV_IDX_FLOW0:  flow0_nxt  = avs_writedata[15:0];
        IPV_IDX_FHIGH0: fhigh0_nxt = avs_writedata[IPV_FHIGH_W-1:0];
        IPV_IDX_FSEL1:  fsel1_nxt  = avs_writedata[IPV_VNUM_W-1:0];
        IPV_IDX_FLOW1:  flow1_nxt  = avs_writedata[15:0];
        IPV_IDX_FHIGH1: fhigh1_nxt = avs_writedata[IPV_FHIGH_W-1:0];
        default: begin
          // Writes to the status word or unmapped words are ignored
          lvl4_nxt = lvl4_r;
        end
      endcase
    end
  end

  // Configuration flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lvl4_r   <= IPV_RST_LVL[1:0];
      lvl5_r   <= IPV_RST_LVL;
      lvl6_r   <= IPV_RST_LVL[IPV_LVL6_W-1:0];
      vbase_r  <= VBA_RESET[IPV_BASE_W-1:0];
      fsel0_r  <= IPV_RST_ZERO[IPV_VNUM_W-1:0];
      fsel1_r  <= IPV_RST_ZERO[IPV_VNUM_W-1:0];
      flow0_r  <= IPV_RST_ZERO;
      fhigh0_r <= IPV_RST_ZERO[IPV_FHIGH_W-1:0];
      flow1_r  <= IPV_RST_ZERO;
      fhigh1_r <= IPV_RST_ZERO[IPV_FHIGH_W-1:0];
    end else begin
      lvl4_r   <= lvl4_nxt;
      lvl5_r   <= lvl5_nxt;
      lvl6_r   <= lvl6_nxt;
      vbase_r  <= vbase_nxt;
      fsel0_r  <= fsel0_nxt;
      fsel1_r  <= fsel1_nxt;
      flow0_r  <= flow0_nxt;
      fhigh0_r <= fhigh0_nxt;
      flow1_r  <= flow1_nxt;
      fhigh1_r <= fhigh1_nxt;
    end
  end

  // ************************************************************
  // Arbitration and vector formation
  // ************************************************************
  // Fast matches are checked first; otherwise the highest level wins
  // and ties fall to the smaller vector number. Software is expected to
  // put fast requests at level two; if it does not, the fast request
  // still wins here, which is one of the allowed undefined outcomes.
  always_comb begin
    logic                  found;
    logic                  hit0;
    logic                  hit1;
    logic [1:0]            best_lvl;
    logic [IPV_VNUM_W-1:0] best_vec;
    logic [1:0]            lvl0;
    logic [1:0]            lvl1;
    found    = 1'b0;
    hit0     = 1'b0;
    hit1     = 1'b0;
    best_lvl = 2'h0;
    best_vec = '0;
    lvl0     = 2'h0;
    lvl1     = 2'h0;
    for (int i = 0; i < IPV_NUM_SRC; i++) begin
      if (pend[i] && (IPV_VNUM[i] == fsel0_r)) begin
        hit0 = 1'b1;
        lvl0 = src_lvl[i];
      end
      if (pend[i] && (IPV_VNUM[i] == fsel1_r)) begin
        hit1 = 1'b1;
        lvl1 = src_lvl[i];
      end
      if (pend[i] && (!found || (src_lvl[i] > best_lvl) ||
          ((src_lvl[i] == best_lvl) && (IPV_VNUM[i] < best_vec)))) begin
        found    = 1'b1;
        best_lvl = src_lvl[i];
        best_vec = IPV_VNUM[i];
      end
    end
    irq_nxt  = found;
    fast_nxt = hit0 | hit1;
    if (hit0) begin
      // Fast zero first, with its own 21-bit address
      clvl_nxt = lvl0;
      vab_nxt  = {fhigh0_r, flow0_r};
    end else if (hit1) begin
      clvl_nxt = lvl1;
      vab_nxt  = {fhigh1_r, flow1_r};
    end else if (found) begin
      clvl_nxt = best_lvl;
      vab_nxt  = {vbase_r, 1'b0, best_vec};
    end else begin
      // Idle: level zero, vector parked at the table base
      clvl_nxt = 2'h0;
      vab_nxt  = {vbase_r, {IPV_LOW_W{1'b0}}};
    end
    if (clvl_nxt > IPV_LVL_TOP) begin
      clvl_nxt = IPV_LVL_TOP;
    end
  end

  // Core-facing flops, one cycle behind the requests
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_r  <= 1'b0;
      clvl_r <= 2'h0;
      fast_r <= 1'b0;
      vab_r  <= {VBA_RESET[IPV_BASE_W-1:0], {IPV_LOW_W{1'b0}}};
    end else begin
      irq_r  <= irq_nxt;
      clvl_r <= clvl_nxt;
      fast_r <= fast_nxt;
      vab_r  <= vab_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign core_irq           = irq_r;
  assign core_level         = clvl_r;
  assign core_fast          = fast_r;
  assign vector_address_bus = vab_r;

endmodule : ipv_ctrl

`default_nettype wire

// [logic/ipv_pkg.sv]
// Package for the interrupt priority and vector logic.
// Assumes a 40 MHz system clock and an Avalon-MM slave with 32-bit data
// whose registers are 16 bits wide and sit one per aligned word.
`default_nettype none

package ipv_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [4:0] IPV_IDX_LVL4   = 5'h04; // General call level
  localparam logic [4:0] IPV_IDX_LVL5   = 5'h05; // irq_level_select_five
  localparam logic [4:0] IPV_IDX_LVL6   = 5'h06; // irq_level_select_six
  localparam logic [4:0] IPV_IDX_VBASE  = 5'h07; // vector_base
  localparam logic [4:0] IPV_IDX_FSEL0  = 5'h08; // fast_irq0_select
  localparam logic [4:0] IPV_IDX_FLOW0  = 5'h09; // fast0_address_low
  localparam logic [4:0] IPV_IDX_FHIGH0 = 5'h0a; // fast0_address_high
  localparam logic [4:0] IPV_IDX_FSEL1  = 5'h0b; // Fast interrupt 1 select
  localparam logic [4:0] IPV_IDX_FLOW1  = 5'h0c; // Fast interrupt 1 address low
  localparam logic [4:0] IPV_IDX_FHIGH1 = 5'h0d; // Fast interrupt 1 address high
  localparam logic [4:0] IPV_IDX_PEND   = 5'h10; // Pending status, active low

  // ************************************************************
  // Field widths and layout
  // ************************************************************
  localparam int IPV_NUM_SRC   = 15; // Peripheral requests handled here
  localparam int IPV_BASE_W    = 14; // Vector base field, bits 13..0
  localparam int IPV_LOW_W     = 7;  // Vector offset bits appended below
  localparam int IPV_VAB_W     = 21; // Full vector address width
  localparam int IPV_VNUM_W    = 6;  // Fast match field, bits 5..0
  localparam int IPV_FHIGH_W   = 5;  // Upper fast address bits
  localparam int IPV_LVL6_W    = 12; // Used bits of the sixth level register

  // ************************************************************
  // Level field encodings
  // ************************************************************
  localparam logic [1:0] IPV_FLD_OFF = 2'h0; // Request disabled
  localparam logic [1:0] IPV_LVL_TOP = 2'h2; // Highest level a request may get

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [15:0] IPV_RST_LVL   = 16'h0000; // All requests disabled
  localparam logic [15:0] IPV_RST_VBA_A = 16'h0000; // Variant A, vector 0x000000
  localparam logic [15:0] IPV_RST_VBA_B = 16'h0080; // Variant B, vector 0x004000
  localparam logic [15:0] IPV_RST_ZERO  = 16'h0000;

  // Vector number of each request, index order matches the level fields
  localparam logic [5:0] IPV_VNUM [IPV_NUM_SRC] = '{
    6'h28, 6'h29, 6'h2a, 6'h2b, 6'h2c, 6'h2d, 6'h2e, 6'h2f,
    6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h35, 6'h36
  };

endpackage : ipv_pkg

`default_nettype wire

// [logic/ipv_lvl_dec.sv]
// Decoder for one two-bit request level field.
// Assumes the field comes from a register on the same clock.
`default_nettype none

module ipv_lvl_dec (
  input  wire logic [1:0] field,   // Raw two-bit level field
  output logic            enabled, // Request may reach the core
  output logic [1:0]      level    // Decoded level 0..2
);
  import ipv_pkg::*;

  // ************************************************************
  // Decode
  // ************************************************************
  // 00 disables, 01/10/11 give levels 0/1/2; level 3 cannot arise
  always_comb begin
    enabled = (field != IPV_FLD_OFF);
    level   = enabled ? (field - 2'h1) : IPV_FLD_OFF;
  end

endmodule : ipv_lvl_dec

`default_nettype wire

// [tb/ipv_ctrl_assertions.sv]
// Checker for ipv_ctrl: bus wait timing, level cap, vector and fast choice.
// Assumes masters hold each request until waitrequest is sampled low.
`default_nettype none
module ipv_ctrl_assertions #(
  parameter logic [15:0] VBA_RESET = 16'h0000 // Variant reset of the base
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [6:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [14:0] irq_req,
  input wire logic        core_irq,
  input wire logic [1:0]  core_level,
  input wire logic        core_fast,
  input wire logic [20:0] vector_address_bus
);
  import ipv_pkg::*;
  // ****
  // Shadow state rebuilt from taken writes
  // ****
  logic [29:0] lv_sh;  // Level fields, two bits per source
  logic [13:0] vb_sh;  // Vector base
  logic [5:0]  f0_sel; // Fast 0 vector number
  logic [20:0] f0_adr; // Fast 0 address
  logic [14:0] en_req; // Enabled and requesting
  logic        f0_hit; // Fast 0 source enabled and requesting
  logic [14:0] p_en;   // Views one edge back, as the outputs see them
  logic        p_f0;
  logic [13:0] p_vb;
  logic [20:0] p_fa;
  // Request view; the fast match is guarded so a stray number never indexes
  always_comb begin
    for (int i = 0; i < 15; i++) en_req[i] = irq_req[i] && lv_sh[2*i+:2] != 2'h0;
    f0_hit = f0_sel >= 6'h28 && f0_sel <= 6'h36 && en_req[4'(f0_sel - 6'h28)];
  end
  // Shadows follow writes at the edge where waitrequest is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lv_sh <= '0; vb_sh <= VBA_RESET[13:0]; f0_sel <= '0; f0_adr <= '0;
      p_en <= '0; p_f0 <= 1'b0; p_vb <= VBA_RESET[13:0]; p_fa <= '0;
    end else begin
      if (avs_write && !avs_waitrequest) begin
        case (avs_address[6:2])
          IPV_IDX_LVL4:   lv_sh[1:0]    <= avs_writedata[1:0];
          IPV_IDX_LVL5:   lv_sh[17:2]   <= avs_writedata[15:0];
          IPV_IDX_LVL6:   lv_sh[29:18]  <= avs_writedata[11:0];
          IPV_IDX_VBASE:  vb_sh         <= avs_writedata[13:0];
          IPV_IDX_FSEL0:  f0_sel        <= avs_writedata[5:0];
          IPV_IDX_FLOW0:  f0_adr[15:0]  <= avs_writedata[15:0];
          IPV_IDX_FHIGH0: f0_adr[20:16] <= avs_writedata[4:0];
          default: ;
        endcase
      end
      p_en <= en_req; p_f0 <= f0_hit; p_vb <= vb_sh; p_fa <= f0_adr;
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request waited more than one cycle");
  idle_ready_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high with no request");
  data_hold_a: assert property (!$past(avs_read) |-> $stable(avs_readdata))
    else $error("read data moved without a read");
  level_cap_a: assert property (core_level != 2'h3)
    else $error("core level three produced");
  quiet_idle_a: assert property (p_en == '0 |->
    !core_irq && vector_address_bus == {p_vb, 7'h00})
    else $error("request or vector without an enabled request");
  req_seen_a: assert property (p_en != '0 |-> core_irq)
    else $error("enabled request not passed on");
  base_upper_a: assert property (core_irq && !core_fast |->
    vector_address_bus[20:6] == {p_vb, 1'b0})
    else $error("vector upper bits differ from base");
  low_winner_a: assert property (core_irq && !core_fast |-> vector_address_bus[5:0] >= 6'h28
    && p_en[4'(vector_address_bus[5:0] - 6'h28)])
    else $error("vector low bits name no pending request");
  fast0_win_a: assert property (p_f0 |->
    core_fast && core_level == 2'h2 && vector_address_bus == p_fa)
    else $error("fast 0 request did not win with its own address");
  cover property (avs_read && !avs_waitrequest);
  cover property (core_fast);
  cover property (core_irq && !core_fast && core_level == 2'h2);
endmodule : ipv_ctrl_assertions
bind ipv_ctrl ipv_ctrl_assertions #(.VBA_RESET(VBA_RESET)) i_ipv_chk (.clk(clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .irq_req(irq_req), .core_irq(core_irq), .core_level(core_level), .core_fast(core_fast),
  .vector_address_bus(vector_address_bus));
`default_nettype wire

// [tb/ipv_core_model.sv]
// Processor core stand-in: takes the request view presented at each edge.
// Assumes the controller outputs are registered on clk.
`default_nettype none
module ipv_core_model (
  input  wire logic        clk,                // System clock
  input  wire logic        core_irq,           // Request
  input  wire logic [1:0]  core_level,         // Level 0..2
  input  wire logic        core_fast,          // Fast vector flag
  input  wire logic [20:0] vector_address_bus, // Vector
  output logic      [24:0] seen                // Last view taken
);
  // A core latches the whole view at once, so a torn update shows up here
  always_ff @(posedge clk) begin
    seen <= {core_irq, core_level, core_fast, vector_address_bus};
  end
endmodule : ipv_core_model
`default_nettype wire

// [tb/irq_priority_vector_logic_tb.sv]
// Self-checking bench for the interrupt priority and vector logic.
// Assumes the package, design, checker and core model are compiled first.
`default_nettype none
`define CMP(nm, e, s) begin num_checks++; if ((s) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, s); end end
module irq_priority_vector_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ipv_pkg::*;
  logic        clk           = 1'b0;  // 40 MHz clock
  logic        sys_rst       = 1'b1;  // Held 16 cycles
  logic [6:0]  avs_address   = 7'h00;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [14:0] irq_req       = 15'h0; // Peripheral requests
  logic        core_irq;
  logic        core_fast;
  logic [1:0]  core_level;
  logic [20:0] vector_address_bus;
  logic [24:0] seen;                  // Core view from the model
  logic        chk_core      = 1'b0;  // Compare core view at next edge
  logic [31:0] exp_q[$];              // Expected results, oldest first
  logic [31:0] e;                     // Note taken off the queue
  logic [5:0]  x;                     // Random fast number
  logic [29:0] lv;                    // Level fields, two bits per source
  logic [13:0] vb;                    // Vector base as written
  logic [20:0] fa[2];                 // Fast addresses
  int          fs[2];                 // Fast sources, -1 for none
  int          num_errors    = 0;
  int          num_checks    = 0;
  integer      seed          = 32'hf3c205bc;
  logic [14:0] fr[3]         = '{15'h000b, 15'h0003, 15'h0001}; // Fast cases
  always #12.5 clk = ~clk;
  ipv_ctrl #(.VBA_RESET(IPV_RST_VBA_B)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_req(irq_req), .core_irq(core_irq),
    .core_level(core_level), .core_fast(core_fast), .vector_address_bus(vector_address_bus));
  ipv_core_model i_core (.clk(clk), .core_irq(core_irq), .core_level(core_level),
    .core_fast(core_fast), .vector_address_bus(vector_address_bus), .seen(seen));
  // ****
  // Monitor: every result takes the oldest note
  // ****
  always @(posedge clk) begin
    if (avs_read && !avs_waitrequest) begin
      e = exp_q.pop_front();
      `CMP("readdata", e, avs_readdata)
    end
    if (chk_core) begin
      e = exp_q.pop_front();
      `CMP("core view", e, {7'h0, seen})
    end
  end
  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic [4:0] idx, input logic wr, input logic [15:0] d);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {16'h0, d};
    if (wr) avs_write <= 1'b1; else avs_read <= 1'b1;
    // No local limit: only the watchdog ends a wait that never finishes
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    bus(idx, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [4:0] idx, input logic [31:0] ex);
    exp_q.push_back(ex);
    bus(idx, 1'b0, 16'h0);
  endtask : rd
  // Level registers from lv, reserved bits written as zero
  task automatic wrlv();
    wr(5'h4, {14'h0, lv[1:0]});
    wr(5'h5, lv[17:2]);
    wr(5'h6, {4'h0, lv[29:18]});
  endtask : wrlv
  // Bench view of the winner: fast 0, fast 1, highest level, lowest number
  function automatic logic [24:0] exp_core(input logic [14:0] r);
    logic [1:0] best;
    logic [5:0] vn;
    logic       hit;
    int         f;
    hit = 1'b0; best = 2'h0; vn = 6'h0; f = -1;
    for (int i = 14; i >= 0; i--)
      if (r[i] && lv[2*i+:2] != 2'h0 && (!hit || lv[2*i+:2] >= best)) begin
        hit = 1'b1; best = lv[2*i+:2]; vn = 6'h28 + 6'(i);
      end
    for (int k = 1; k >= 0; k--)
      if (fs[k] >= 0) if (r[fs[k]] && lv[2*fs[k]+:2] != 2'h0) f = k;
    if (f >= 0) return {1'b1, 2'h2, 1'b1, fa[f]};
    return hit ? {1'b1, best - 2'h1, 1'b0, vb, 1'b0, vn} : {4'h0, vb, 7'h0};
  endfunction : exp_core
  function automatic logic [31:0] pend(input logic [14:0] r);
    logic [14:0] en;
    for (int i = 0; i < 15; i++) en[i] = lv[2*i+:2] != 2'h0;
    return {17'h1, ~(r & en)};
  endfunction : pend
  // Drive requests, let two edges land, then compare the core view
  task automatic chk(input logic [14:0] r);
    irq_req <= r;
    repeat (2) @(posedge clk);
    exp_q.push_back({7'h0, exp_core(r)});
    chk_core <= 1'b1;
    @(posedge clk);
    chk_core <= 1'b0;
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // Watchdog, far beyond the roughly two thousand cycles the tests take
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
  initial begin
    lv = '0; vb = 14'h0080; fs = '{-1, -1}; fa = '{21'h0, 21'h0};
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 4; i < 9; i++) rd(5'(i), (i == 7) ? 32'h80 : 32'h0);
    rd(5'h10, 32'h0000ffff);
    wr(5'h1f, 16'hffff);
    rd(5'h1f, 32'h0);
    chk(15'h7fff);
    $display("reset test done");
    for (int n = 0; n < 24; n++) begin
      lv = 30'($random(seed)); vb = 14'($random(seed)); x = 6'($random(seed));
      // A source picked as fast must sit at level two, as software is bound to do
      if (x >= 6'h28 && x <= 6'h36) lv[2*(x-6'h28)+:2] = 2'h3;
      wrlv();
      wr(5'h7, {2'b0, vb});
      wr(5'h8, {10'h0, x});
      rd(5'h4, {30'h0, lv[1:0]});
      rd(5'h5, {16'h0, lv[17:2]});
      rd(5'h6, {20'h0, lv[29:18]});
      rd(5'h7, {18'h0, vb});
      rd(5'h8, {26'h0, x});
      wr(5'h8, 16'h0);
      chk(15'($random(seed)));
      chk(15'($random(seed)));
    end
    $display("register and arbitration test done");
    for (int i = 0; i < 15; i++)
      for (int c = 0; c < 4; c++) begin
        lv = '0; lv[2*i+:2] = 2'(c);
        wrlv();
        chk(15'h1 << i);
        rd(5'h10, pend(15'h1 << i));
      end
    $display("field decode test done");
    lv = '0; lv[1:0] = 2'h3; lv[3:2] = 2'h3; lv[7:6] = 2'h3;
    wrlv();
    for (int k = 0; k < 2; k++) begin
      fs[k] = 3 - 2 * k; fa[k] = 21'($random(seed));
      wr(5'(8 + 3 * k), 16'(6'h28 + 6'(fs[k])));
      wr(5'(9 + 3 * k), fa[k][15:0]);
      wr(5'(10 + 3 * k), {11'h0, fa[k][20:16]});
    end
    rd(5'h9, {16'h0, fa[0][15:0]});
    rd(5'ha, {27'h0, fa[0][20:16]});
    foreach (fr[j]) chk(fr[j]);
    $display("fast interrupt test done");
    give_verdict();
  end
endmodule : irq_priority_vector_logic_tb
`default_nettype wire
